// *** hdl/pss_defs.vh ***
// constants for the preset speed and mode switch block
// assumes a 32-bit axi4-lite bus with byte addresses in the low 8 bits
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
// ==========================================
// register byte offsets
`define PSS_OFF_MODE 8'h00
`define PSS_OFF_ACCEL 8'h04
`define PSS_OFF_DECEL 8'h08
`define PSS_OFF_SCURVE 8'h0C
`define PSS_OFF_AOFS 8'h10
`define PSS_OFF_AFILT 8'h14
`define PSS_OFF_STAT 8'h18
`define PSS_PRESET_BASE 3'h1
// ==========================================
// field positions of the mode register
`define PSS_MODE_LSB 0
`define PSS_MODE_MSB 3
`define PSS_SRC_LSB 8
`define PSS_SRC_MSB 9
// ==========================================
// control mode and selector codes
`define PSS_MODE_POS 4'h0
`define PSS_MODE_SPD 4'h1
`define PSS_MODE_TRQ 4'h2
`define PSS_MODE_PS 4'h3
`define PSS_MODE_PT 4'h4
`define PSS_MODE_ST 4'h5
`define PSS_SRC_TWO 2'h1
`define PSS_SRC_AIN 2'h2
`define PSS_SRC_ALL 2'h3
// ==========================================
// loop codes, one-hot
`define PSS_LOOP_POS 3'h1
`define PSS_LOOP_SPD 3'h2
`define PSS_LOOP_TRQ 3'h4
// ==========================================
// limits and answers
`define PSS_SPEED_MAX 16'h4E20
`define PSS_SPEED_MIN 16'hB1E0
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2
`endif

// *** hdl/pss_top.v ***
// preset speed selection and control loop switching for a servo drive
// assumes all pins synchronous to mclk apart from the select and mode
// inputs, which are resynchronised here; software uses axi4-lite
//
// Function
// - presets are used only with control mode 1, 3 or 5
// - eight signed presets, each held within -20000 to 20000 r/min
// - presets take effect only with speed source selector 1 to 3
// - select one, two, three weigh 1, 2, 4; index n picks preset n+1
// - selector 1 decodes selects one and two only, presets one to four
// - selector 2 as 1, but both selects on means analog speed reference
// - selector 3 decodes all three selects, presets one to eight
// - speed command ramps with acceleration, deceleration and s-curve times
// - selects changing together may briefly decode an intermediate preset
// - mode switch input changes loops only with control mode 3, 4 or 5
// - mode 3 position/speed, 4 position/torque, 5 speed/torque
// - a mode switch change is recognised within 10 ms
// - pulses before positioning complete after entering position are dropped
// - in speed control positioning complete carries rotation detected
// - speed/torque switching takes torque from analog two, offset, filter
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "pss_defs.vh"

module pss_top #(
  parameter SPW = 16,
  parameter RAMPW = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // host selection pins
  input wire speed_select_one,
  input wire speed_select_two,
  input wire speed_select_three,
  input wire mode_switch_input,
  input wire cmd_pulse_in,
  // drive internal status and analog samples
  input wire pos_done_in,
  input wire rotation_detected,
  input wire signed [SPW-1:0] analog_speed_ref,
  input wire signed [SPW-1:0] analog_two_in,
  // results
  output reg signed [SPW-1:0] speed_cmd_reg,
  output reg signed [SPW-1:0] torque_cmd_reg,
  output reg [2:0] loop_sel_reg,
  output reg positioning_complete,
  output reg cmd_pulse_out
);

  // ==========================================
  // software registers
  reg [3:0] control_mode_setting;
  reg [1:0] speed_source_selector;
  reg [RAMPW-1:0] ramp_accel_time;
  reg [RAMPW-1:0] ramp_decel_time;
  reg [RAMPW-1:0] s_curve_time;
  reg signed [SPW-1:0] analog_two_offset;
  reg [3:0] analog_two_filter_time;
  reg signed [SPW-1:0] preset_mem [0:7];
  // bus state
  reg [7:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg w_have_reg;
  // synchronisers
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  // block state
  reg [2:0] idx_reg;
  reg use_preset_reg;
  reg use_analog_reg;
  reg gate_block_reg;
  reg [RAMPW:0] ramp_cnt_reg;
  reg signed [SPW-1:0] filt_reg;
  integer i;

  wire signed [SPW-1:0] wr_speed;
  wire signed [SPW-1:0] clamp_speed;
  wire wr_fire;
  wire [2:0] idx_next;
  wire pres_mode;
  wire [2:0] loop_next;
  reg use_preset_next;
  reg use_analog_next;

  // ==========================================
  // write channel: address and data taken in either order
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_speed = w_data_reg[SPW-1:0];
  // out of range speeds are clipped rather than refused
  assign clamp_speed = (wr_speed > $signed(`PSS_SPEED_MAX)) ? `PSS_SPEED_MAX :
    (wr_speed < $signed(`PSS_SPEED_MIN)) ? `PSS_SPEED_MIN : wr_speed;

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSS_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      control_mode_setting <= `PSS_MODE_POS;
      speed_source_selector <= 2'h0;
      ramp_accel_time <= {RAMPW{1'b0}};
      ramp_decel_time <= {RAMPW{1'b0}};
      s_curve_time <= {RAMPW{1'b0}};
      analog_two_offset <= {SPW{1'b0}};
      analog_two_filter_time <= 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        preset_mem[i] <= {SPW{1'b0}};
      end
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PSS_RESP_OKAY;
        // strobes ignored: every register is one word, written whole
        if (aw_addr_reg[7:5] == `PSS_PRESET_BASE) begin
          preset_mem[aw_addr_reg[4:2]] <= clamp_speed;
        end else begin
          case (aw_addr_reg)
            `PSS_OFF_MODE: begin
              control_mode_setting <= w_data_reg[`PSS_MODE_MSB:`PSS_MODE_LSB];
              speed_source_selector <= w_data_reg[`PSS_SRC_MSB:`PSS_SRC_LSB];
            end
            `PSS_OFF_ACCEL: ramp_accel_time <= w_data_reg[RAMPW-1:0];
            `PSS_OFF_DECEL: ramp_decel_time <= w_data_reg[RAMPW-1:0];
            `PSS_OFF_SCURVE: s_curve_time <= w_data_reg[RAMPW-1:0];
            `PSS_OFF_AOFS: analog_two_offset <= w_data_reg[SPW-1:0];
            `PSS_OFF_AFILT: analog_two_filter_time <= w_data_reg[3:0];
            default: s_axi_bresp <= `PSS_RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // ==========================================
  // read channel: one read at a time, answer one cycle after address
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
        (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready));
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PSS_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr[7:5] == `PSS_PRESET_BASE) begin
          s_axi_rdata <= {{(32-SPW){preset_mem[s_axi_araddr[4:2]][SPW-1]}},
            preset_mem[s_axi_araddr[4:2]]};
        end else begin
          case (s_axi_araddr)
            `PSS_OFF_MODE: begin
              s_axi_rdata[`PSS_MODE_MSB:`PSS_MODE_LSB] <= control_mode_setting;
              s_axi_rdata[`PSS_SRC_MSB:`PSS_SRC_LSB] <= speed_source_selector;
            end
            `PSS_OFF_ACCEL: s_axi_rdata[RAMPW-1:0] <= ramp_accel_time;
            `PSS_OFF_DECEL: s_axi_rdata[RAMPW-1:0] <= ramp_decel_time;
            `PSS_OFF_SCURVE: s_axi_rdata[RAMPW-1:0] <= s_curve_time;
            `PSS_OFF_AOFS: s_axi_rdata[SPW-1:0] <= analog_two_offset;
            `PSS_OFF_AFILT: s_axi_rdata[3:0] <= analog_two_filter_time;
            // live state: speed command, loop, source flags, index
            `PSS_OFF_STAT: s_axi_rdata <= {speed_cmd_reg, 5'h00, loop_sel_reg,
              1'b0, positioning_complete, use_analog_reg, use_preset_reg,
              1'b0, idx_reg};
            default: s_axi_rresp <= `PSS_RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // ==========================================
  // two-flop synchronisers; a couple of cycles is far inside 10 ms
  always @(posedge mclk) begin
    if (rst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {mode_switch_input, speed_select_three,
        speed_select_two, speed_select_one};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================
  // loop selection from mode and switch input
  assign loop_next =
    (control_mode_setting == `PSS_MODE_SPD) ? `PSS_LOOP_SPD :
    (control_mode_setting == `PSS_MODE_TRQ) ? `PSS_LOOP_TRQ :
    (control_mode_setting == `PSS_MODE_PS) ?
      (pin_sync_reg[3] ? `PSS_LOOP_SPD : `PSS_LOOP_POS) :
    (control_mode_setting == `PSS_MODE_PT) ?
      (pin_sync_reg[3] ? `PSS_LOOP_TRQ : `PSS_LOOP_POS) :
    (control_mode_setting == `PSS_MODE_ST) ?
      (pin_sync_reg[3] ? `PSS_LOOP_TRQ : `PSS_LOOP_SPD) :
    `PSS_LOOP_POS;

  // ==========================================
  // preset index decode; no settling filter, so a multi-bit change
  // may pass through an intermediate preset for a cycle
  assign idx_next = (speed_source_selector == `PSS_SRC_ALL) ?
    pin_sync_reg[2:0] : {1'b0, pin_sync_reg[1:0]};
  assign pres_mode = (control_mode_setting == `PSS_MODE_SPD) ||
    (control_mode_setting == `PSS_MODE_PS) ||
    (control_mode_setting == `PSS_MODE_ST);

  always @* begin
    use_preset_next = 1'b0;
    use_analog_next = 1'b0;
    if (pres_mode && (speed_source_selector != 2'h0)) begin
      if ((speed_source_selector == `PSS_SRC_AIN) && (idx_next == 3'h3)) begin
        use_analog_next = 1'b1;
      end else begin
        use_preset_next = 1'b1;
      end
    end
  end

  // ==========================================
  // selection state, pulse gate and positioning complete output
  always @(posedge mclk) begin
    if (rst) begin
      idx_reg <= 3'h0;
      use_preset_reg <= 1'b0;
      use_analog_reg <= 1'b0;
      loop_sel_reg <= `PSS_LOOP_POS;
      gate_block_reg <= 1'b0;
      positioning_complete <= 1'b0;
      cmd_pulse_out <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      use_preset_reg <= use_preset_next;
      use_analog_reg <= use_analog_next;
      loop_sel_reg <= loop_next;
      // entering position blocks pulses until done; entry wins over clear
      if (loop_next == `PSS_LOOP_POS && loop_sel_reg != `PSS_LOOP_POS) begin
        gate_block_reg <= 1'b1;
      end else if (pos_done_in) begin
        gate_block_reg <= 1'b0;
      end
      // pulses pass only in the position loop with the gate open: in-position falls during normal moves
      cmd_pulse_out <= cmd_pulse_in && (loop_sel_reg == `PSS_LOOP_POS) &&
        !gate_block_reg;
      positioning_complete <= (loop_sel_reg == `PSS_LOOP_SPD) ?
        rotation_detected : pos_done_in;
    end
  end

  // ==========================================
  // speed ramp: one r/min per interval; interval 0 steps at once.
  // near the target the interval doubles to round off the approach
  wire signed [SPW-1:0] target = use_preset_reg ? preset_mem[idx_reg] :
    analog_speed_ref;
  wire signed [SPW:0] diff = {target[SPW-1], target} -
    {speed_cmd_reg[SPW-1], speed_cmd_reg};
  wire [SPW:0] mag = diff[SPW] ? -diff : diff;
  wire rising = (diff > 0) ? !speed_cmd_reg[SPW-1] :
    (speed_cmd_reg[SPW-1] || speed_cmd_reg == 0);
  wire [RAMPW-1:0] base_t = rising ? ramp_accel_time : ramp_decel_time;
  wire [RAMPW:0] interval = (mag[SPW-1:0] < s_curve_time[SPW-1:0]) ?
    {base_t, 1'b0} : {1'b0, base_t};

  always @(posedge mclk) begin
    if (rst) begin
      speed_cmd_reg <= {SPW{1'b0}};
      ramp_cnt_reg <= {(RAMPW+1){1'b0}};
    end else if (diff == 0) begin
      ramp_cnt_reg <= {(RAMPW+1){1'b0}};
    end else if (base_t == 0) begin
      speed_cmd_reg <= target;
    end else if (ramp_cnt_reg >= interval - 1'b1) begin
      ramp_cnt_reg <= {(RAMPW+1){1'b0}};
      speed_cmd_reg <= diff[SPW] ? speed_cmd_reg - 1'b1 :
        speed_cmd_reg + 1'b1;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 1'b1;
    end
  end

  // ==========================================
  // torque command: analog two with offset and first-order filter in
  // speed/torque switching, analog speed input otherwise
  wire signed [SPW-1:0] trq_raw = analog_two_in + analog_two_offset;
  wire signed [SPW-1:0] trq_step = (trq_raw - filt_reg) >>> analog_two_filter_time;

  always @(posedge mclk) begin
    if (rst) begin
      filt_reg <= {SPW{1'b0}};
      torque_cmd_reg <= {SPW{1'b0}};
    end else begin
      filt_reg <= (analog_two_filter_time == 4'h0) ? trq_raw :
        filt_reg + trq_step;
      torque_cmd_reg <= (control_mode_setting == `PSS_MODE_ST) ?
        filt_reg : analog_speed_ref;
    end
  end

endmodule

// *** testbench/pss_chk.sv ***
// checker for pss_top: bus answers, pulse gate, status pin meaning
// assumes one clock, mclk, and a synchronous active high rst
`timescale 1ns/10ps
`include "pss_defs.vh"
// ==========================================
// checker
module pss_chk #(
  parameter SPW = 16,
  parameter RAMPW = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // pins
  input wire cmd_pulse_in,
  input wire pos_done_in,
  input wire rotation_detected,
  input wire [2:0] loop_sel_reg,
  input wire positioning_complete,
  input wire cmd_pulse_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // transfer steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // fresh entry into position with the axis not yet in place
  sequence s_enter;
    loop_sel_reg == `PSS_LOOP_POS && $past(loop_sel_reg) != `PSS_LOOP_POS && !pos_done_in;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_pulse_cause: assert property (cmd_pulse_out |->
    $past(cmd_pulse_in) && $past(loop_sel_reg) == `PSS_LOOP_POS) else $error("stray pulse");
  a_gate_closed: assert property (s_enter ##1 !pos_done_in |=> !cmd_pulse_out)
    else $error("pulse passed before in-position");
  a_pulse_pass: assert property (cmd_pulse_in && loop_sel_reg == `PSS_LOOP_POS &&
    $past(pos_done_in) && $past(loop_sel_reg) == `PSS_LOOP_POS |=> cmd_pulse_out)
    else $error("pulse lost after in-position");
  a_rot_speed: assert property (loop_sel_reg == `PSS_LOOP_SPD ##1
    loop_sel_reg == `PSS_LOOP_SPD |-> positioning_complete == $past(rotation_detected))
    else $error("speed loop status wrong");
  a_in_place: assert property (loop_sel_reg != `PSS_LOOP_SPD ##1
    loop_sel_reg != `PSS_LOOP_SPD |-> positioning_complete == $past(pos_done_in))
    else $error("in-position status wrong");
  a_loop_onehot: assert property (loop_sel_reg inside {1, 2, 4})
    else $error("loop code not one-hot");
endmodule
bind pss_top pss_chk #(.SPW(SPW), .RAMPW(RAMPW)) u_chk (
  .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .cmd_pulse_in, .pos_done_in, .rotation_detected, .loop_sel_reg,
  .positioning_complete, .cmd_pulse_out
);

// *** testbench/pss_host.sv ***
// host controller model: select, mode switch and pulse pins
// assumes bench requests change just after rising mclk edges
`timescale 1ns/10ps
// ==========================================
// host model
module pss_host #(
  parameter int WAIT = 8
) (
  // clock
  input wire mclk,
  // bench requests
  input wire [2:0] want_sel,
  input wire want_mode,
  input wire preq,
  input wire prude,
  // drive feedback
  input wire positioning_complete,
  // pins to the drive
  output reg [2:0] sel,
  output reg mode_switch_input,
  output reg cmd_pulse_in
);
  reg pend = 1'b0;
  int hold = 0;
  // pins idle low from time zero
  initial begin
    sel = 3'h0;
    mode_switch_input = 1'b0;
    cmd_pulse_in = 1'b0;
  end
  // one select bit per edge: a step never jumps through others
  always @(posedge mclk) begin
    sel <= sel ^ ((sel ^ want_sel) & (~(sel ^ want_sel) + 3'h1));
    mode_switch_input <= want_mode;
  end
  // pulses held until in-position has settled, unless told early
  always @(posedge mclk) begin
    hold <= positioning_complete ? hold + 1 : 0;
    cmd_pulse_in <= (pend || preq) && (prude || hold >= WAIT);
    pend <= (pend || preq) && !(prude || hold >= WAIT);
  end
endmodule

// *** testbench/test_pss_top.sv ***
// bench for pss_top: registers, preset choice, loop switching, pulses
// assumes pss_host drives the pins and pss_chk is bound to the dut
`timescale 1ns/10ps
`include "pss_defs.vh"
// ==========================================
// bench
module test_pss_top;
  localparam logic [1:0] OK = `PSS_RESP_OKAY;
  localparam logic [1:0] ERR = `PSS_RESP_SLVERR;
  localparam int WAIT = 8;
  logic mclk = 0;
  logic rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d, seed = 8;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, want_mode = 0, preq = 0, prude = 0;
  logic pos_done_in = 0, rotation_detected = 0;
  logic signed [15:0] analog_speed_ref = 0, analog_two_in = 0;
  logic [2:0] want_sel = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] sel, loop_sel_reg;
  wire mode_switch_input, cmd_pulse_in, positioning_complete, cmd_pulse_out;
  wire signed [15:0] speed_cmd_reg, torque_cmd_reg;
  int fail_count = 0, n_compared = 0, npul = 0, n0, pre[8];
  int lim[4] = '{30000, -30000, 20000, -20001};
  pss_top #(.SPW(16), .RAMPW(16)) dut (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .speed_select_one(sel[0]),
    .speed_select_two(sel[1]), .speed_select_three(sel[2]), .mode_switch_input,
    .cmd_pulse_in, .pos_done_in, .rotation_detected, .analog_speed_ref, .analog_two_in,
    .speed_cmd_reg, .torque_cmd_reg, .loop_sel_reg, .positioning_complete, .cmd_pulse_out);
  pss_host #(.WAIT(WAIT)) host (.mclk, .want_sel, .want_mode, .preq, .prude,
    .positioning_complete, .sel, .mode_switch_input, .cmd_pulse_in);
  initial forever #4 mclk = ~mclk;
  // pulse tally; rotation flag wiggles so the status pin has work
  always @(posedge mclk) begin
    npul <= npul + int'(cmd_pulse_out);
    rotation_detected <= ~rotation_detected;
  end
  // watchdog, far beyond the thousand or so cycles the run needs
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    $display("[ERR] %0t watchdog", $time);
    results();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int cl(input int v);
    return v > 20000 ? 20000 : (v < -20000 ? -20000 : v);
  endfunction
  // model of the chosen speed with mode 1
  function automatic int xs(input int s, input int i);
    int k;
    k = (s == 3) ? i : i & 3;
    if (s == 2 && k == 3) return analog_speed_ref;
    return pre[k];
  endfunction
  function automatic logic [2:0] lp(input int m, input logic s);
    case (m)
      1: return `PSS_LOOP_SPD;
      2: return `PSS_LOOP_TRQ;
      3: return s ? `PSS_LOOP_SPD : `PSS_LOOP_POS;
      4: return s ? `PSS_LOOP_TRQ : `PSS_LOOP_POS;
      5: return s ? `PSS_LOOP_TRQ : `PSS_LOOP_SPD;
      default: return `PSS_LOOP_POS;
    endcase
  endfunction
  task automatic cmp_bus(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t bus %h not %h", $time, g, e);
    end
  endtask
  task automatic cmp_port(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t pin %h not %h", $time, g, e);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (pa || pw) begin
      @(posedge mclk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    while (!s_axi_bvalid) @(posedge mclk);
    s_axi_bready <= 0;
    cmp_bus({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] v);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge mclk);
    v = s_axi_rdata;
    s_axi_rready <= 0;
    cmp_bus({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // pins walk one bit at a time; then decode and ramp get six edges
  task automatic pick(input int i);
    @(posedge mclk);
    want_sel <= i[2:0];
    do @(posedge mclk); while (sel !== i[2:0]);
    repeat (6) @(posedge mclk);
  endtask
  task automatic sw(input logic s);
    @(posedge mclk);
    want_mode <= s;
    repeat (5) @(posedge mclk);
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    repeat (2) @(posedge mclk);
    cmp_port({13'h0, loop_sel_reg}, 16'h0001);
    rd(`PSS_OFF_MODE, OK, d);
    cmp_bus(d, 32'h0000_0000);
    rd(8'h1C, ERR, d);
    cmp_bus(d, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0001, ERR);
    foreach (lim[j]) begin
      wr(8'h20, 32'(lim[j]), OK);
      rd(8'h20, OK, d);
      cmp_bus(d, 32'(cl(lim[j])));
    end
    $display("test registers done");
    for (int o = 4; o < 24; o += 4) if (o != 16) wr(8'(o), 32'h0000_0000, OK);
    foreach (pre[k]) begin
      pre[k] = int'(rnd() % 40001) - 20000;
      wr(8'h20 + 8'(4 * k), 32'(pre[k]), OK);
    end
    analog_speed_ref <= 16'(rnd() % 20000);
    for (int s = 1; s < 4; s++) begin
      wr(`PSS_OFF_MODE, 32'(s << 8 | 1), OK);
      for (int i = 0; i < 8; i++) begin
        pick(i);
        cmp_port(speed_cmd_reg, 16'(xs(s, i)));
      end
    end
    // every mode code with selector 3: presets only in modes 1, 3 and 5
    for (int m = 0; m < 6; m++) begin
      wr(`PSS_OFF_MODE, 32'(3 << 8 | m), OK);
      repeat (4) @(posedge mclk);
      rd(`PSS_OFF_STAT, OK, d);
      cmp_bus(d & 32'h0000_0010, (m % 2 == 1) ? 32'h0000_0010 : 32'h0);
    end
    wr(`PSS_OFF_MODE, 32'h0000_0001, OK);
    repeat (4) @(posedge mclk);
    rd(`PSS_OFF_STAT, OK, d);
    cmp_bus(d & 32'h0000_0010, 32'h0000_0000);
    $display("test presets done");
    for (int m = 0; m < 6; m++) begin
      wr(`PSS_OFF_MODE, 32'(3 << 8 | m), OK);
      for (int s = 0; s < 2; s++) begin
        sw(s[0]);
        cmp_port({13'h0, loop_sel_reg}, {13'h0, lp(m, s[0])});
      end
    end
    $display("test loops done");
    pre[0] = 0;
    pre[1] = 12;
    wr(`PSS_OFF_MODE, 32'h0000_0301, OK);
    wr(8'h20, 32'h0000_0000, OK);
    wr(8'h24, 32'h0000_000C, OK);
    pick(0);
    wr(`PSS_OFF_ACCEL, 32'h0000_0003, OK);
    wr(`PSS_OFF_DECEL, 32'h0000_0003, OK);
    for (int j = 1; j >= 0; j--) begin
      pick(j);
      cmp_port({15'h0, speed_cmd_reg != pre[j]}, 16'h0001);
      repeat (60) @(posedge mclk);
      cmp_port(speed_cmd_reg, 16'(pre[j]));
    end
    $display("test ramp done");
    wr(`PSS_OFF_MODE, 32'h0000_0303, OK);
    sw(1'b1);
    sw(1'b0);
    n0 = npul;
    prude <= 1;
    preq <= 1;
    @(posedge mclk);
    prude <= 0;
    preq <= 0;
    repeat (4) @(posedge mclk);
    cmp_port(16'(npul - n0), 16'h0000);
    pos_done_in <= 1;
    preq <= 1;
    @(posedge mclk);
    preq <= 0;
    repeat (WAIT + 6) @(posedge mclk);
    cmp_port(16'(npul - n0), 16'h0001);
    $display("test pulses done");
    analog_two_in <= 16'(rnd() % 1000);
    wr(`PSS_OFF_AOFS, 32'h0000_0064, OK);
    wr(`PSS_OFF_MODE, 32'h0000_0305, OK);
    sw(1'b1);
    cmp_port(torque_cmd_reg, analog_two_in + 16'h0064);
    $display("test torque done");
    results();
  end
endmodule
